// ==== verif/pbls_boot_monitor.sv ====
/* assertions on the boot sequencer top ports.
   assumes one clock, clk_en high while images are copied; bound at the foot. */
`default_nettype none
module pbls_boot_monitor #(
  parameter SLOT_BYTES = 32'h0001_0000,
  parameter WS_WORDS = 1024
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic second_cpu_reset_exit,
  input wire logic fabric_user_mode,
  input wire logic flash_req_ff,
  input wire logic [31:0] flash_addr_ff,
  input wire logic flash_ack,
  input wire logic [31:0] flash_rdata,
  input wire logic ocram_we_ff,
  input wire logic [13:0] ocram_addr_ff,
  input wire logic [31:0] ocram_wdata_ff,
  input wire logic [31:0] first_cpu_pc_ff,
  input wire logic first_cpu_go_ff,
  input wire logic second_cpu_go_ff,
  input wire logic icache_en_ff,
  input wire logic bpred_en_ff,
  input wire logic fpu_en_ff,
  input wire logic [2:0] iomux_bsel_ff,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_rvalid_ff,
  input wire logic [1:0] s_axi_rresp_ff,
  input wire logic [31:0] s_axi_rdata_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // first word index of the boot workspace at the top of on-chip ram
  localparam int WS_LO = 16384 - WS_WORDS;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // cpu start, release and source decode
  reset_pc_a: assert property ($rose(aresetn) |-> first_cpu_pc_ff == 32'h0 && !first_cpu_go_ff)
    else $error("first cpu not at reset vector");
  second_go_a: assert property ($rose(second_cpu_reset_exit) |-> ##[1:4] second_cpu_go_ff)
    else $error("second cpu not released");
  flash_src_a: assert property (flash_req_ff |-> iomux_bsel_ff > 3'h1)
    else $error("flash read for a non-flash source");
  // image copy and workspace clear in on-chip ram
  req_hold_a: assert property (flash_req_ff && !flash_ack |=> flash_req_ff && $stable(flash_addr_ff))
    else $error("flash request changed before ack");
  ram_copy_a: assert property (ocram_we_ff && ocram_addr_ff < WS_LO |-> $past(flash_ack)
    && ocram_wdata_ff == $past(flash_rdata) && ocram_addr_ff == 14'(($past(flash_addr_ff) % SLOT_BYTES) >> 2))
    else $error("ram write not a copy of the flash word");
  ws_zero_a: assert property (ocram_we_ff && ocram_addr_ff >= WS_LO |-> ocram_wdata_ff == 32'h0)
    else $error("workspace written with data");
  // handoff conditions and unmapped register reads
  unit_enable_a: assert property ($rose(first_cpu_go_ff) && first_cpu_pc_ff != 32'h0
    |-> icache_en_ff && bpred_en_ff && fpu_en_ff)
    else $error("units off at handoff");
  fabric_wait_a: assert property ($rose(first_cpu_go_ff) && first_cpu_pc_ff == 32'h0 |-> $past(fabric_user_mode))
    else $error("fabric handoff before user mode");
  rd_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:6] != 26'h0
    |=> s_axi_rvalid_ff && s_axi_rresp_ff == 2'b10 && s_axi_rdata_ff == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind pbls_boot_sequencer pbls_boot_monitor #(.SLOT_BYTES(SLOT_BYTES), .WS_WORDS(WS_WORDS)) mon_u (.*);
`default_nettype wire

// ==== verif/pbls_flash_model.sv ====
/* boot flash model: four image slots of 64 words, filled by the bench.
   assumes a slot size of 0x100 bytes and word-aligned requests. */
`default_nettype none
module pbls_flash_model (
  input wire logic aclk,
  input wire logic slow,
  input wire logic flash_req_ff,
  input wire logic [31:0] flash_addr_ff,
  output logic flash_ack,
  output logic [31:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255]; // vectors, header, code, crc
  logic [1:0] wait_ff = 2'h0;
  initial flash_ack = 1'b0;
  initial flash_rdata = 32'h5a5a_5a5a;
  // one ack per held request, at once or after three idle cycles
  always @(posedge aclk) begin
    flash_ack <= 1'b0;
    flash_rdata <= ~flash_rdata; // undriven data flips every cycle
    if (flash_req_ff && !flash_ack && wait_ff == {slow, slow}) begin
      flash_ack <= 1'b1;
      flash_rdata <= mem[flash_addr_ff[9:2]];
      wait_ff <= 2'h0;
    end else if (flash_req_ff && !flash_ack) begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_processor_boot_loader_sequencer.sv ====
/* self-checking bench of the boot sequencer: register master, images, boots.
   assumes the design, its monitor and the flash model are compiled first. */
`default_nettype none
`include "pbls_defines.vh"
module tb_processor_boot_loader_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, clk_en = 1, slow = 0, warm_boot_req = 0, second_cpu_reset_exit = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] bsel_strap = 3'h6;
  logic [1:0] csel_strap = 2'h2;
  logic fabric_user_mode = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid_ff, s_axi_arready, s_axi_rvalid_ff, flash_req_ff, flash_ack;
  logic ocram_we_ff, first_cpu_go_ff, second_cpu_go_ff, icache_en_ff, bpred_en_ff, fpu_en_ff, wdog0_start_ff;
  logic flash_init_ff, go_q = 0;
  logic [1:0] s_axi_bresp_ff, s_axi_rresp_ff, pll_csel_ff;
  logic [31:0] s_axi_rdata_ff, flash_addr_ff, flash_rdata, ocram_wdata_ff, first_cpu_pc_ff, second_cpu_pc_ff;
  logic [13:0] ocram_addr_ff;
  logic [2:0] iomux_bsel_ff;
  logic [31:0] lf = 32'hc15a;
  logic [31:0] sh [0:16383];
  logic [33:0] qr[$], qb[$], qg[$], q2[$], nf = 0;
  logic [1:0] sq[$];
  int miscompares = 0, n_compared = 0, ngo = 0, ni = 0;

  pbls_boot_sequencer #(.SLOT_BYTES(32'h100), .WS_WORDS(16)) dut_u (.*);
  pbls_flash_model flash_u (.*);

  // 20 MHz clock
  initial forever #25 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  function automatic logic [31:0] crc_w(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `PBLS_CRC_POLY : 32'h0);
    return c;
  endfunction

  task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic to_err(input string s);
    miscompares++;
    $display("[ERR] %s expected answer seen timeout", s);
    finish_test();
  endtask

  // image in slot s; f: 0 good, 1 bad magic, 2 bad checksum, 3 bad crc
  task automatic build(input int s, input logic [31:0] ent, input int f);
    logic [31:0] c;
    logic [15:0] cs;
    int b;
    b = s * 64;
    c = 32'hffff_ffff;
    cs = 16'h0;
    for (int i = 0; i < 16; i++) flash_u.mem[b + i] = rnd();
    flash_u.mem[b + 16] = (f == 1) ? ~`PBLS_VALID_WORD : `PBLS_VALID_WORD;
    flash_u.mem[b + 17] = {16'h0054, 16'h0001};
    flash_u.mem[b + 18] = {16'h0000, 16'h0203};
    for (int i = 64; i < 74; i++) cs = cs + {8'h0, flash_u.mem[b + i / 4][8 * (i % 4) +: 8]};
    flash_u.mem[b + 18][31:16] = (f == 2) ? ~cs : cs;
    flash_u.mem[b + 19] = ent;
    for (int i = 0; i < 20; i++) c = crc_w(c, flash_u.mem[b + i]);
    flash_u.mem[b + 20] = (f == 3) ? c : ~c;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    qb.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1;
    s_axi_wdata <= d;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid_ff) break;
    end
    s_axi_bready <= 0;
    if (n == 50) to_err("write");
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int n;
    qr.push_back(e);
    @(posedge aclk);
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid_ff) break;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    if (n == 50) to_err("read");
  endtask

  task automatic pulse(input int w);
    @(posedge aclk);
    if (w) warm_boot_req <= 1;
    else second_cpu_reset_exit <= 1;
    @(posedge aclk);
    warm_boot_req <= 0;
    second_cpu_reset_exit <= 0;
  endtask

  task automatic rst(input logic [2:0] b);
    @(posedge aclk);
    aresetn <= 0;
    bsel_strap <= b;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
  endtask

  task automatic wait_go(input int k);
    for (int n = 0; n < 3000 && ngo < k; n++) @(posedge aclk);
    if (ngo < k) to_err("handoff");
  endtask

  task automatic chk_slots(input logic [7:0] e, input int k);
    cmp("slot_count", 34'(k), 34'(sq.size()));
    for (int i = 0; i < k; i++) cmp("slot", {32'h0, e[2 * i +: 2]}, {32'h0, sq[i]});
    sq = {};
  endtask

  // watcher: takes the oldest note for each result that appears
  always @(posedge aclk) begin
    go_q <= first_cpu_go_ff;
    if (s_axi_rvalid_ff && s_axi_rready) cmp("rdata", qr.pop_front(), {s_axi_rresp_ff, s_axi_rdata_ff});
    if (s_axi_bvalid_ff && s_axi_bready) cmp("bresp", qb.pop_front(), {s_axi_bresp_ff, 32'h0});
    if (first_cpu_go_ff && !go_q) begin
      ngo++;
      cmp("first_pc", qg.pop_front(), {2'b00, first_cpu_pc_ff});
      cmp("wdog0", 34'h1, {33'h0, wdog0_start_ff});
    end
    if (flash_init_ff) ni++;
    if (second_cpu_go_ff) cmp("second_pc", q2.pop_front(), {2'b00, second_cpu_pc_ff});
    if (ocram_we_ff) sh[ocram_addr_ff] <= ocram_wdata_ff;
    if (flash_req_ff && flash_ack) begin
      nf++;
      if (flash_addr_ff[7:0] == 8'h0) sq.push_back(flash_addr_ff[9:8]);
    end
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge aclk);
    to_err("run");
  end

  // main sequence
  initial begin
    logic [31:0] e2, r;
    e2 = rnd();
    r = rnd();
    build(0, rnd(), 1);
    build(1, rnd(), 3);
    build(2, e2, 0);
    build(3, rnd(), 2);
    qg.push_back({2'b00, e2});
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(32'h08, 34'h0);
    rd(32'h04, {29'h0, 2'h2, 3'h6});
    rd(32'h40, {2'b10, 32'h0});
    wr(32'h18, r, 2'b10);
    wr(32'h08, r, 2'b00);
    rd(32'h08, {2'b00, r});
    q2.push_back({2'b00, r});
    pulse(0);
    wait_go(1);
    chk_slots(8'b10_01_00, 3);
    cmp("handoff", {26'h0, 3'b111, 2'h2, 3'h6}, {26'h0, icache_en_ff, bpred_en_ff, fpu_en_ff, pll_csel_ff, iomux_bsel_ff});
    for (int i = 0; i < 21; i++) cmp("ocram", {2'b00, flash_u.mem[128 + i]}, {2'b00, sh[i]});
    for (int i = 16368; i < 16384; i++) cmp("workspace", 34'h0, {2'b00, sh[i]});
    rd(32'h10, 34'h2);
    // warm boot reusing the image in ram
    wr(32'h0c, `PBLS_SWSTATE_OK, 2'b00);
    nf = 0;
    qg.push_back({2'b00, e2});
    pulse(1);
    wait_go(2);
    cmp("flash_reads", 34'h0, nf);
    // warm boot from the last slot, wrapping, slow flash
    wr(32'h0c, 32'h0, 2'b00);
    wr(32'h10, 32'h3, 2'b00);
    slow <= 1;
    qg.push_back({2'b00, e2});
    pulse(1);
    wait_go(3);
    chk_slots(8'b10_01_00_11, 4);
    // reserved source goes to the fabric image
    nf = 0;
    qg.push_back(34'h0);
    rst(3'h0);
    wait_go(4);
    cmp("flash_reads", 34'h0, nf);
    // fabric source waits for user mode
    fabric_user_mode <= 0;
    qg.push_back(34'h0);
    rst(3'h1);
    repeat (40) @(posedge aclk);
    cmp("early_go", 34'h4, 34'(ngo));
    clk_en <= 0;
    fabric_user_mode <= 1;
    repeat (10) @(posedge aclk);
    cmp("frozen_go", 34'h4, 34'(ngo));
    clk_en <= 1;
    wait_go(5);
    cmp("flash_reads", 34'h0, nf);
    cmp("flash_inits", 34'h2, 34'(ni));
    finish_test();
  end
endmodule
`default_nettype wire

// ==== verilog/pbls_boot_sequencer.v ====
/*
 * boot sequencer: captures straps, separates the two cpus, copies and
 * validates a second-stage image from flash into on-chip ram, retries
 * further slots, falls back to the fabric, and hands off.
 * assumes: single clock aclk, inputs synchronous to it, a flash port that
 * answers each held request with a one-cycle ack, and a write-only ram port.
 */
// Overview of operation
// RQ1: cpus start at the reset exception address
// RQ2: second cpu jumps to its start register
// RQ3: first cpu uses boot-source and clock-select
// RQ4: straps captured into boot info at reset
// RQ5: decode boot-source codes, pairs by voltage
// RQ6: flash boot copies image into ram
// RQ7: fabric boot waits for fabric user mode
// RQ8: cold fabric boot executes at address zero
// RQ9: cold flash tries four images, then fabric
// RQ10: warm boot reuses valid ram image
// RQ11: warm miss loads last image, retries, fabric
// RQ12: image valid only if header and crc
// RQ13: validation word must equal fixed magic
// RQ14: program length spans whole image with crc
// RQ15: header checksum covers bytes 0x40 to 0x49
// RQ16: top 4 KB reserved, image max 60 KB
// RQ17: workspace overwritten again on every reset
// RQ18: enable caches, units, watchdog, plls, muxing
// RQ19: image puts vectors at ram start
// RQ20: branch to image entry point when valid
// RQ21: crc-32 unreflected, preset ones, inverted
// RQ22: crc covers base up to crc word
// RQ23: second stage writes magic to state register
// RQ24: reserved code goes straight to fabric check
// RQ25: slots 0 to 3 retried with wrap
`default_nettype none
`include "pbls_defines.vh"

module pbls_boot_sequencer #(
  parameter SLOT_BYTES = 32'h0001_0000,
  parameter WS_WORDS = 1024
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid_ff,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp_ff,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [31:0] s_axi_araddr,
  output reg s_axi_rvalid_ff,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata_ff,
  output reg [1:0] s_axi_rresp_ff,
  input wire [2:0] bsel_strap,
  input wire [1:0] csel_strap,
  input wire warm_boot_req,
  input wire second_cpu_reset_exit,
  input wire fabric_user_mode,
  output reg flash_req_ff,
  output reg [31:0] flash_addr_ff,
  input wire flash_ack,
  input wire [31:0] flash_rdata,
  output reg ocram_we_ff,
  output reg [13:0] ocram_addr_ff,
  output reg [31:0] ocram_wdata_ff,
  output reg [31:0] first_cpu_pc_ff,
  output reg first_cpu_go_ff,
  output reg [31:0] second_cpu_pc_ff,
  output reg second_cpu_go_ff,
  output reg icache_en_ff,
  output reg bpred_en_ff,
  output reg fpu_en_ff,
  output reg wdog0_start_ff,
  output reg [1:0] pll_csel_ff,
  output reg [2:0] iomux_bsel_ff,
  output reg flash_init_ff
);

  localparam S_IDLE = 4'h0, S_CLEAR = 4'h1, S_DISPATCH = 4'h2, S_LOAD = 4'h3, S_NEXT = 4'h4;
  localparam S_FABRIC = 4'h5, S_HANDOFF = 4'h6, S_DONE = 4'h7, S_FAIL = 4'h8;
  localparam [13:0] WS_FIRST = 14'h3fff - WS_WORDS[13:0] + 14'h0001;

  // one unreflected crc-32 step over a word, msb first
  function [31:0] crc_word;
    input [31:0] crc;
    input [31:0] d;
    integer i;
    reg [31:0] c;
    begin
      c = crc;
      for (i = 31; i >= 0; i = i - 1) begin
        c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `PBLS_CRC_POLY : 32'h0000_0000);
      end
      crc_word = c;
    end
  endfunction

  reg [3:0] state_ff, aw_idx_ff, wstrb_ff;
  reg capture_pend_ff, warm_ff, fabric_fb_ff, aw_ok_ff, w_ok_ff, aw_map_ff;
  reg [2:0] bsel_ff;
  reg [1:0] csel_ff, slot_ff, tries_ff, lastld_ff;
  reg [13:0] word_ff;
  reg [15:0] len_ff, csum_ff;
  reg [31:0] crc_ff, entry_ff, img_entry_ff, cpu2_start_ff, swstate_ff, wdata_ff;
  wire [13:0] last_word = len_ff[15:2] - 14'h0001;
  wire [15:0] byte_sum = {8'h00, flash_rdata[7:0]} + {8'h00, flash_rdata[15:8]} +
    {8'h00, flash_rdata[23:16]} + {8'h00, flash_rdata[31:24]};
  wire [15:0] low_sum = {8'h00, flash_rdata[7:0]} + {8'h00, flash_rdata[15:8]};
  wire is_flash = (bsel_ff != `PBLS_BSEL_RSVD) && (bsel_ff != `PBLS_BSEL_FABRIC);
  wire got = flash_req_ff && flash_ack;
  wire wr_fire = aw_ok_ff && w_ok_ff && !s_axi_bvalid_ff;
  wire dev_lastld = (state_ff == S_LOAD) && got && (word_ff == last_word) && (word_ff > `PBLS_HDR_ENTRY_W);
  // header and image checks on the word just returned
  reg bad_word;
  always @* begin
    bad_word = 1'b0;
    if (word_ff == `PBLS_HDR_VALID_W) begin
      bad_word = (flash_rdata != `PBLS_VALID_WORD); // [RQ13] [RQ12]
    end else if (word_ff == `PBLS_HDR_LEN_W) begin
      bad_word = (flash_rdata[17:16] != 2'b00) || (flash_rdata[31:16] < `PBLS_HDR_MIN_LEN) ||
        (flash_rdata[31:16] > `PBLS_MAX_IMG); // [RQ14] [RQ16]
    end else if (word_ff == `PBLS_HDR_CSUM_W) begin
      bad_word = (csum_ff + low_sum != flash_rdata[31:16]); // [RQ15]
    end else if (word_ff > `PBLS_HDR_ENTRY_W && word_ff == last_word) begin
      bad_word = ((crc_ff ^ `PBLS_CRC_XOR) != flash_rdata); // [RQ21] [RQ12]
    end
  end
  // axi write channels are taken independently, in either order
  assign s_axi_awready = !aw_ok_ff;
  assign s_axi_wready = !w_ok_ff;
  assign s_axi_arready = !s_axi_rvalid_ff;
  // axi4-lite write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_idx_ff <= 4'h0;
      aw_map_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid_ff <= 1'b0;
      s_axi_bresp_ff <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_ok_ff) begin
        aw_ok_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[5:2];
        aw_map_ff <= (s_axi_awaddr[31:6] == 26'h0000000);
      end
      if (s_axi_wvalid && !w_ok_ff) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid_ff <= 1'b1;
        s_axi_bresp_ff <= (aw_map_ff && aw_idx_ff <= `PBLS_OFF_ENTRY) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid_ff && s_axi_bready) begin
        s_axi_bvalid_ff <= 1'b0;
      end
    end
  end

  // software-writable registers; the device update of last-loaded wins
  integer b;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu2_start_ff <= `PBLS_RST_CPU2_START;
      swstate_ff <= `PBLS_RST_SWSTATE;
      lastld_ff <= 2'b00;
    end else if (clk_en) begin
      if (wr_fire && aw_map_ff) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (wstrb_ff[b] && aw_idx_ff == `PBLS_OFF_CPU2_START) begin
            cpu2_start_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
          end
          if (wstrb_ff[b] && aw_idx_ff == `PBLS_OFF_SWSTATE) begin
            swstate_ff[8*b +: 8] <= wdata_ff[8*b +: 8]; // [RQ23]
          end
        end
        if (wstrb_ff[0] && aw_idx_ff == `PBLS_OFF_LASTLD) begin
          lastld_ff <= wdata_ff[1:0];
        end
      end
      if (dev_lastld && !bad_word) begin
        lastld_ff <= slot_ff;
      end
    end
  end

  // axi4-lite read path, one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid_ff <= 1'b0;
      s_axi_rdata_ff <= 32'h0000_0000;
      s_axi_rresp_ff <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_arvalid && !s_axi_rvalid_ff) begin
        s_axi_rvalid_ff <= 1'b1;
        s_axi_rresp_ff <= 2'b00;
        s_axi_rdata_ff <= 32'h0000_0000;
        if (s_axi_araddr[31:6] != 26'h0000000 || s_axi_araddr[5:2] > `PBLS_OFF_ENTRY) begin
          s_axi_rresp_ff <= 2'b10;
        end else begin
          case (s_axi_araddr[5:2])
            `PBLS_OFF_STATUS: begin
              s_axi_rdata_ff <= {20'h00000, fabric_fb_ff, state_ff == S_FAIL, state_ff == S_DONE,
                warm_ff, tries_ff, slot_ff, state_ff};
            end
            `PBLS_OFF_BOOTINFO: s_axi_rdata_ff <= {27'h0000000, csel_ff, bsel_ff}; // [RQ3]
            `PBLS_OFF_CPU2_START: s_axi_rdata_ff <= cpu2_start_ff;
            `PBLS_OFF_SWSTATE: s_axi_rdata_ff <= swstate_ff;
            `PBLS_OFF_LASTLD: s_axi_rdata_ff <= {30'h00000000, lastld_ff};
            default: s_axi_rdata_ff <= entry_ff;
          endcase
        end
      end else if (s_axi_rvalid_ff && s_axi_rready) begin
        s_axi_rvalid_ff <= 1'b0;
      end
    end
  end

  // second cpu goes straight to its programmed start address
  always @(posedge aclk) begin
    if (!aresetn) begin
      second_cpu_pc_ff <= `PBLS_RST_RESET_VEC; // [RQ1]
      second_cpu_go_ff <= 1'b0;
    end else if (clk_en) begin
      second_cpu_go_ff <= 1'b0;
      if (second_cpu_reset_exit) begin
        second_cpu_pc_ff <= cpu2_start_ff; // [RQ2]
        second_cpu_go_ff <= 1'b1;
      end
    end
  end

  // main boot sequence for the first cpu
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_IDLE;
      capture_pend_ff <= 1'b1;
      warm_ff <= 1'b0;
      fabric_fb_ff <= 1'b0;
      bsel_ff <= 3'h0;
      csel_ff <= 2'h0;
      slot_ff <= 2'h0;
      tries_ff <= 2'h0;
      word_ff <= 14'h0000;
      len_ff <= 16'h0000;
      csum_ff <= 16'h0000;
      crc_ff <= `PBLS_CRC_INIT;
      entry_ff <= `PBLS_RST_RESET_VEC;
      img_entry_ff <= 32'h0000_0000;
      flash_req_ff <= 1'b0;
      flash_addr_ff <= 32'h0000_0000;
      ocram_we_ff <= 1'b0;
      ocram_addr_ff <= 14'h0000;
      ocram_wdata_ff <= 32'h0000_0000;
      first_cpu_pc_ff <= `PBLS_RST_RESET_VEC; // [RQ1]
      first_cpu_go_ff <= 1'b0;
      icache_en_ff <= 1'b0;
      bpred_en_ff <= 1'b0;
      fpu_en_ff <= 1'b0;
      wdog0_start_ff <= 1'b0;
      pll_csel_ff <= 2'h0;
      iomux_bsel_ff <= 3'h0;
      flash_init_ff <= 1'b0;
    end else if (clk_en) begin
      ocram_we_ff <= 1'b0;
      flash_init_ff <= 1'b0;
      wdog0_start_ff <= 1'b0;
      if (warm_boot_req) begin
        // warm restart keeps software registers and the last entry
        state_ff <= S_IDLE;
        capture_pend_ff <= 1'b1;
        warm_ff <= 1'b1;
        flash_req_ff <= 1'b0;
        first_cpu_go_ff <= 1'b0;
        first_cpu_pc_ff <= `PBLS_RST_RESET_VEC; // [RQ1]
      end else begin
        case (state_ff)
          S_IDLE: begin
            if (capture_pend_ff) begin
              bsel_ff <= bsel_strap; // [RQ4]
              csel_ff <= csel_strap; // [RQ4]
              capture_pend_ff <= 1'b0;
              fabric_fb_ff <= 1'b0;
              ocram_addr_ff <= WS_FIRST;
              state_ff <= S_CLEAR;
            end
          end
          S_CLEAR: begin
            ocram_we_ff <= 1'b1; // [RQ17]
            ocram_wdata_ff <= 32'h0000_0000;
            if (ocram_we_ff) begin
              ocram_addr_ff <= ocram_addr_ff + 14'h0001;
            end
            if (ocram_we_ff && ocram_addr_ff == 14'h3fff) begin
              ocram_we_ff <= 1'b0;
              state_ff <= S_DISPATCH;
            end
          end
          S_DISPATCH: begin
            pll_csel_ff <= csel_ff; // [RQ18] [RQ3]
            iomux_bsel_ff <= bsel_ff; // [RQ18] [RQ3]
            tries_ff <= 2'h0;
            word_ff <= 14'h0000;
            crc_ff <= `PBLS_CRC_INIT;
            csum_ff <= 16'h0000;
            slot_ff <= warm_ff ? lastld_ff : 2'h0; // [RQ11] [RQ9]
            if (bsel_ff == `PBLS_BSEL_FABRIC) begin
              state_ff <= S_FABRIC; // [RQ5] [RQ7]
            end else if (bsel_ff == `PBLS_BSEL_RSVD) begin
              fabric_fb_ff <= 1'b1;
              state_ff <= S_FABRIC; // [RQ24]
            end else if (warm_ff && swstate_ff == `PBLS_SWSTATE_OK) begin
              state_ff <= S_HANDOFF; // [RQ10]
            end else begin
              flash_init_ff <= is_flash; // [RQ18] [RQ5]
              state_ff <= S_LOAD;
            end
          end
          S_LOAD: begin
            if (!flash_req_ff) begin
              flash_req_ff <= 1'b1;
              flash_addr_ff <= ({30'h00000000, slot_ff} * SLOT_BYTES) + {16'h0000, word_ff, 2'b00};
            end else if (flash_ack) begin
              flash_req_ff <= 1'b0;
              ocram_we_ff <= 1'b1; // [RQ6]
              ocram_addr_ff <= word_ff;
              ocram_wdata_ff <= flash_rdata;
              word_ff <= word_ff + 14'h0001;
              if (word_ff == `PBLS_HDR_VALID_W) begin
                csum_ff <= byte_sum;
              end else if (word_ff == `PBLS_HDR_LEN_W) begin
                csum_ff <= csum_ff + byte_sum;
                len_ff <= flash_rdata[31:16]; // [RQ14]
              end else if (word_ff == `PBLS_HDR_ENTRY_W) begin
                img_entry_ff <= flash_rdata;
              end
              if (word_ff != last_word || word_ff <= `PBLS_HDR_ENTRY_W) begin
                crc_ff <= crc_word(crc_ff, flash_rdata); // [RQ22]
              end
              if (bad_word) begin
                state_ff <= S_NEXT; // [RQ12]
              end else if (dev_lastld) begin
                entry_ff <= img_entry_ff; // [RQ20]
                state_ff <= S_HANDOFF;
              end
            end
          end
          S_NEXT: begin
            word_ff <= 14'h0000;
            crc_ff <= `PBLS_CRC_INIT;
            csum_ff <= 16'h0000;
            if (tries_ff == 2'h3) begin
              fabric_fb_ff <= 1'b1;
              state_ff <= S_FABRIC; // [RQ9] [RQ11]
            end else begin
              tries_ff <= tries_ff + 2'h1;
              slot_ff <= slot_ff + 2'h1; // [RQ25]
              state_ff <= S_LOAD;
            end
          end
          S_FABRIC: begin
            if (fabric_user_mode) begin
              entry_ff <= `PBLS_FABRIC_ENTRY; // [RQ8] [RQ7]
              state_ff <= S_HANDOFF;
            end else if (fabric_fb_ff) begin
              state_ff <= S_FAIL;
            end
          end
          S_HANDOFF: begin
            icache_en_ff <= 1'b1; // [RQ18]
            bpred_en_ff <= 1'b1;
            fpu_en_ff <= 1'b1;
            wdog0_start_ff <= 1'b1;
            first_cpu_pc_ff <= entry_ff; // [RQ20] [RQ10]
            first_cpu_go_ff <= 1'b1;
            state_ff <= S_DONE;
          end
          S_DONE: state_ff <= S_DONE;
          S_FAIL: state_ff <= S_FAIL;
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/pbls_defines.vh ====
/*
 * constants of the boot sequencer: register offsets, field positions,
 * reset values, image header layout and magic values.
 * assumes inclusion by bare name from the sequencer source.
 */
`ifndef PBLS_DEFINES_VH
`define PBLS_DEFINES_VH

// register word indexes on the axi4-lite port; byte address is four times the index
`define PBLS_OFF_STATUS 4'h0
`define PBLS_OFF_BOOTINFO 4'h1
`define PBLS_OFF_CPU2_START 4'h2
`define PBLS_OFF_SWSTATE 4'h3
`define PBLS_OFF_LASTLD 4'h4
`define PBLS_OFF_ENTRY 4'h5

// status register field positions
`define PBLS_ST_STATE_LSB 0
`define PBLS_ST_SLOT_LSB 4
`define PBLS_ST_TRIES_LSB 6
`define PBLS_ST_WARM_BIT 8
`define PBLS_ST_DONE_BIT 9
`define PBLS_ST_FAIL_BIT 10
`define PBLS_ST_FABRIC_BIT 11

// reset values
`define PBLS_RST_CPU2_START 32'h0000_0000
`define PBLS_RST_SWSTATE 32'h0000_0000
`define PBLS_RST_RESET_VEC 32'h0000_0000

// boot-source codes
`define PBLS_BSEL_RSVD 3'h0
`define PBLS_BSEL_FABRIC 3'h1

// image header layout, word indexes in the image and minimum length in bytes
`define PBLS_HDR_VALID_W 14'h0010
`define PBLS_HDR_LEN_W 14'h0011
`define PBLS_HDR_CSUM_W 14'h0012
`define PBLS_HDR_ENTRY_W 14'h0013
`define PBLS_HDR_MIN_LEN 16'h0054

// magic values and addresses
`define PBLS_VALID_WORD 32'h3130_5341
`define PBLS_SWSTATE_OK 32'h4953_5756
`define PBLS_OCRAM_BASE 32'hffff_0000
`define PBLS_FABRIC_ENTRY 32'h0000_0000
`define PBLS_CRC_POLY 32'h04c1_1db7
`define PBLS_CRC_INIT 32'hffff_ffff
`define PBLS_CRC_XOR 32'hffff_ffff

// on-chip ram sizes in bytes
`define PBLS_OCRAM_BYTES 32'h0001_0000
`define PBLS_WS_BYTES 32'h0000_1000
`define PBLS_MAX_IMG 16'hf000

`endif
